/* File: design/cbdc_channel_config.sv */
// channel buffer, descriptor pointer and vector mask registers with users
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module cbdc_channel_config
   import cbdc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output cbdc_pkg::cbdc_word_type s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // transmit character escaping
   input wire logic [1:0] tx_protocol_mode,
   input wire logic [7:0] tx_octet,
   input wire logic tx_octet_valid,
   output logic tx_escape_q,
   // transmit buffer
   input wire logic tx_init_cmd,
   input wire logic tx_off_cmd,
   input wire logic tx_word_stored,
   input wire logic tx_word_taken,
   input wire logic tx_packet_end_held,
   output logic tx_allocated_q,
   output logic [12:0] tx_allocated_words_q,
   output logic tx_refill_request,
   output logic tx_forward_enable,
   // receive buffer
   input wire logic [9:0] rx_packet_words,
   input wire logic rx_packet_complete,
   output logic rx_forward,
   output logic rx_code_invalid,
   output logic tx_refill_code_invalid,
   // descriptor fetch and list heads
   input wire logic rx_first_request,
   input wire logic tx_first_request,
   input wire logic rx_abort_branch_cmd,
   input wire logic tx_abort_branch_cmd,
   output logic rx_fetch_q,
   output cbdc_pkg::cbdc_word_type rx_fetch_address_q,
   output logic tx_fetch_q,
   output cbdc_pkg::cbdc_word_type tx_fetch_address_q,
   output cbdc_pkg::cbdc_word_type rx_list_head_q,
   output cbdc_pkg::cbdc_word_type tx_list_head_q,
   // interrupt vector generation
   input wire logic [31:0] channel_event,
   output logic tx_vector_write_q,
   output logic [31:0] tx_vector_q,
   output logic [2:0] tx_vector_queue_q,
   output logic rx_vector_write_q,
   output logic [31:0] rx_vector_q,
   output logic [2:0] rx_vector_queue_q
);

   cbdc_word_type escape_map_q;
   cbdc_word_type buffer_config_q;
   cbdc_word_type rx_desc_ptr_q;
   cbdc_word_type tx_desc_ptr_q;
   cbdc_word_type int_mask_q;

   logic aw_held_q;
   logic w_held_q;
   cbdc_addr_type awaddr_q;
   cbdc_word_type wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   logic write_hit;
   logic read_hit;
   cbdc_word_type read_value;

   logic [12:0] tx_size;
   logic [3:0] tx_fwd_code;
   logic [3:0] tx_refill_code;
   logic [3:0] rx_code;
   logic [13:0] tx_fill_q;
   logic [13:0] tx_free;
   cbdc_word_type tx_pending;
   cbdc_word_type rx_pending;

   // write channel: address and data taken in either order
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready = !w_held_q && !s_axi_bvalid;
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         awaddr_q <= 12'h000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end
      else if (do_write)
      begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
      else if (do_write)
      begin
         w_held_q <= 1'b0;
      end
   end

   always_comb
   begin
      write_hit = 1'b1;
      case ({awaddr_q[11:2], 2'h0})
         TX_ESCAPE_MAP_OFFSET, BUFFER_CONFIG_OFFSET, RX_DESC_PTR_OFFSET,
         TX_DESC_PTR_OFFSET, INT_MASK_OFFSET: write_hit = 1'b1;
         default: write_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= write_hit ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // register store; unwritable bits are forced to zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         escape_map_q <= TX_ESCAPE_MAP_RESET;
         buffer_config_q <= BUFFER_CONFIG_RESET;
         rx_desc_ptr_q <= RX_DESC_PTR_RESET;
         tx_desc_ptr_q <= TX_DESC_PTR_RESET;
         int_mask_q <= INT_MASK_RESET;
      end
      else if (do_write)
      begin
         case ({awaddr_q[11:2], 2'h0})
            TX_ESCAPE_MAP_OFFSET: escape_map_q <= cbdc_merge(escape_map_q,
               wdata_q, wstrb_q, TX_ESCAPE_MAP_BITS);
            BUFFER_CONFIG_OFFSET: buffer_config_q <= cbdc_merge(
               buffer_config_q, wdata_q, wstrb_q, BUFFER_CONFIG_BITS);
            RX_DESC_PTR_OFFSET: rx_desc_ptr_q <= cbdc_merge(rx_desc_ptr_q,
               wdata_q, wstrb_q, DESC_PTR_BITS);
            TX_DESC_PTR_OFFSET: tx_desc_ptr_q <= cbdc_merge(tx_desc_ptr_q,
               wdata_q, wstrb_q, DESC_PTR_BITS);
            INT_MASK_OFFSET: int_mask_q <= cbdc_merge(int_mask_q,
               wdata_q, wstrb_q, INT_MASK_BITS);
            default: int_mask_q <= int_mask_q;
         endcase
      end
   end

   // read channel
   assign s_axi_arready = !s_axi_rvalid;

   always_comb
   begin
      read_hit = 1'b1;
      read_value = 32'h0000_0000;
      case ({s_axi_araddr[11:2], 2'h0})
         TX_ESCAPE_MAP_OFFSET: read_value = escape_map_q;
         BUFFER_CONFIG_OFFSET: read_value = buffer_config_q;
         RX_DESC_PTR_OFFSET: read_value = rx_desc_ptr_q;
         TX_DESC_PTR_OFFSET: read_value = tx_desc_ptr_q;
         INT_MASK_OFFSET: read_value = int_mask_q;
         default: read_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= AXI_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= read_value;
         s_axi_rresp <= read_hit ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // transmit escape decision, one cycle after the octet
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_escape_q <= 1'b0;
      end
      else
      begin
         tx_escape_q <= tx_octet_valid
            && (tx_protocol_mode == OCTET_SYNC_PPP_MODE)
            && (tx_octet <= LAST_CONTROL_CHAR)
            && escape_map_q[tx_octet[4:0]];
      end
   end

   // buffer config fields
   assign tx_size = buffer_config_q[TX_BUF_SIZE_LSB +: 13];
   assign tx_fwd_code = buffer_config_q[TX_FWD_CODE_LSB +: 4];
   assign tx_refill_code = buffer_config_q[TX_REFILL_CODE_LSB +: 4];
   assign rx_code = buffer_config_q[RX_CODE_LSB +: 4];
   assign rx_code_invalid = rx_code > LAST_SHARED_CODE;
   assign tx_refill_code_invalid = tx_refill_code > LAST_SHARED_CODE;

   // allocation is captured at init so later size writes do not move it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_allocated_q <= 1'b0;
         tx_allocated_words_q <= 13'h0000;
      end
      else if (tx_off_cmd)
      begin
         tx_allocated_q <= 1'b0;
         tx_allocated_words_q <= 13'h0000;
      end
      else if (tx_init_cmd)
      begin
         tx_allocated_q <= 1'b1;
         tx_allocated_words_q <= tx_size;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_fill_q <= 14'h0000;
      end
      else if (tx_off_cmd || tx_init_cmd || !tx_allocated_q)
      begin
         tx_fill_q <= 14'h0000;
      end
      else if (tx_word_stored && !tx_word_taken
         && tx_fill_q < {1'b0, tx_allocated_words_q})
      begin
         tx_fill_q <= tx_fill_q + 14'h0001;
      end
      else if (tx_word_taken && !tx_word_stored && tx_fill_q != 14'h0000)
      begin
         tx_fill_q <= tx_fill_q - 14'h0001;
      end
   end

   assign tx_free = {1'b0, tx_allocated_words_q} - tx_fill_q;
   // software keeps forward plus refill below size
   assign tx_refill_request = tx_allocated_q && !tx_refill_code_invalid
      && tx_free >= {4'h0, cbdc_threshold_words(tx_refill_code)};
   assign tx_forward_enable = tx_allocated_q && (tx_packet_end_held
      || tx_fill_q >= {4'h0, cbdc_threshold_words(tx_fwd_code)});
   // invalid receive code: only complete packets are forwarded
   assign rx_forward = rx_packet_complete || (!rx_code_invalid
      && rx_packet_words >= cbdc_threshold_words(rx_code));

   // descriptor fetch requests and list heads
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_fetch_q <= 1'b0;
         rx_fetch_address_q <= 32'h0000_0000;
         rx_list_head_q <= 32'h0000_0000;
      end
      else
      begin
         rx_fetch_q <= rx_first_request;
         if (rx_first_request)
         begin
            rx_fetch_address_q <= rx_desc_ptr_q;
         end
         if (rx_abort_branch_cmd)
         begin
            rx_list_head_q <= rx_desc_ptr_q;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_fetch_q <= 1'b0;
         tx_fetch_address_q <= 32'h0000_0000;
         tx_list_head_q <= 32'h0000_0000;
      end
      else
      begin
         tx_fetch_q <= tx_first_request;
         if (tx_first_request)
         begin
            tx_fetch_address_q <= tx_desc_ptr_q;
         end
         if (tx_abort_branch_cmd)
         begin
            tx_list_head_q <= tx_desc_ptr_q;
         end
      end
   end

   // vector generation; there is no pin here, the pin is decided elsewhere
   // descriptors behind the pointers are software's to keep valid
   assign tx_pending = channel_event & ~int_mask_q & TX_VECTOR_BITS;
   assign rx_pending = channel_event & ~int_mask_q & RX_VECTOR_BITS;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_vector_write_q <= 1'b0;
         tx_vector_q <= 32'h0000_0000;
         tx_vector_queue_q <= 3'h0;
         rx_vector_write_q <= 1'b0;
         rx_vector_q <= 32'h0000_0000;
         rx_vector_queue_q <= 3'h0;
      end
      else
      begin
         tx_vector_write_q <= |tx_pending;
         tx_vector_q <= tx_pending;
         tx_vector_queue_q <= buffer_config_q[TX_QUEUE_LSB +: 3];
         rx_vector_write_q <= |rx_pending;
         rx_vector_q <= rx_pending;
         rx_vector_queue_q <= buffer_config_q[RX_QUEUE_LSB +: 3];
      end
   end

endmodule

/* File: design/cbdc_pkg.sv */
// constants and helpers for the channel buffer and descriptor config block
package cbdc_pkg;

   typedef logic [31:0] cbdc_word_type;
   typedef logic [11:0] cbdc_addr_type;

   // register byte offsets
   localparam cbdc_addr_type TX_ESCAPE_MAP_OFFSET = 12'h018;
   localparam cbdc_addr_type BUFFER_CONFIG_OFFSET = 12'h020;
   localparam cbdc_addr_type RX_DESC_PTR_OFFSET = 12'h024;
   localparam cbdc_addr_type TX_DESC_PTR_OFFSET = 12'h028;
   localparam cbdc_addr_type INT_MASK_OFFSET = 12'h02c;

   // reset values
   localparam cbdc_word_type TX_ESCAPE_MAP_RESET = 32'h0000_0000;
   localparam cbdc_word_type BUFFER_CONFIG_RESET = 32'h0020_0000;
   localparam cbdc_word_type RX_DESC_PTR_RESET = 32'h0000_0000;
   localparam cbdc_word_type TX_DESC_PTR_RESET = 32'h0000_0000;
   localparam cbdc_word_type INT_MASK_RESET = 32'h0000_0000;

   // writable bits, all others read as zero; then the event bits that feed each vector
   localparam cbdc_word_type TX_ESCAPE_MAP_BITS = 32'hffff_ffff;
   localparam cbdc_word_type BUFFER_CONFIG_BITS = 32'hffff_ff7f;
   localparam cbdc_word_type DESC_PTR_BITS = 32'hffff_fffc;
   localparam cbdc_word_type INT_MASK_BITS = 32'h50c1_7fed;
   localparam cbdc_word_type TX_VECTOR_BITS = 32'h50c1_0000;
   localparam cbdc_word_type RX_VECTOR_BITS = 32'h0000_7fed;

   // buffer config field positions (low bit)
   localparam int TX_QUEUE_LSB = 29;
   localparam int TX_BUF_SIZE_LSB = 16;
   localparam int TX_FWD_CODE_LSB = 12;
   localparam int TX_REFILL_CODE_LSB = 8;
   localparam int RX_QUEUE_LSB = 4;
   localparam int RX_CODE_LSB = 0;

   // interrupt mask bit positions
   localparam int TX_ABORT_MASK_BIT = 30;
   localparam int HOLD_TRANSMIT_ABORT_MASK_BIT = 28;
   localparam int TRANSMIT_UNDERRUN_MASK_BIT = 23;
   localparam int TRANSMIT_FRAME_END_MASK_BIT = 22;
   localparam int TRANSMIT_COMMAND_DONE_MASK_BIT = 16;
   localparam int RECEIVE_ABORT_MASK_BIT = 14;
   localparam int RECEIVE_FRAME_END_MASK_BIT = 13;
   localparam int HOLD_RECEIVE_ABORT_MASK_BIT = 12;
   localparam int MAX_LENGTH_EXCEEDED_MASK_BIT = 11;
   localparam int MEMORY_UNIT_OVERFLOW_MASK_BIT = 10;
   localparam int CRC_ERROR_MASK_BIT = 9;
   localparam int INVALID_LENGTH_MASK_BIT = 8;
   localparam int RECEIVE_OVERFLOW_MASK_BIT = 7;
   localparam int SHORT_FRAME_MASK_BIT = 6;
   localparam int INTERFRAME_FILL_CHANGE_MASK_BIT = 5;
   localparam int SHORT_FRAME_DROPPED_MASK_BIT = 3;
   localparam int SILENT_DISCARD_MASK_BIT = 2;
   localparam int RECEIVE_COMMAND_DONE_MASK_BIT = 0;

   localparam logic [1:0] OCTET_SYNC_PPP_MODE = 2'h2;
   localparam logic [7:0] LAST_CONTROL_CHAR = 8'h1f;
   localparam logic [3:0] LAST_SHARED_CODE = 4'h9;
   localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
   localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

   // threshold code to words
   function automatic logic [9:0] cbdc_threshold_words(input logic [3:0] code);
      logic [9:0] w;
      w = 10'h001;
      case (code)
         4'h0: w = 10'h001;
         4'h1: w = 10'h004;
         4'h2: w = 10'h008;
         4'h3: w = 10'h00c;
         4'h4: w = 10'h010;
         4'h5: w = 10'h018;
         4'h6: w = 10'h020;
         4'h7: w = 10'h028;
         4'h8: w = 10'h030;
         4'h9: w = 10'h040;
         4'ha: w = 10'h060;
         4'hb: w = 10'h080;
         4'hc: w = 10'h0c0;
         4'hd: w = 10'h100;
         4'he: w = 10'h180;
         default: w = 10'h200;
      endcase
      return w;
   endfunction

   // byte-strobe merge restricted to writable bits
   function automatic cbdc_word_type cbdc_merge(input cbdc_word_type old,
      input cbdc_word_type data, input logic [3:0] strb,
      input cbdc_word_type bits);
      cbdc_word_type r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return r & bits;
   endfunction

endpackage

/* File: sim/cbdc_chk.sv */
// assertion checker for the channel config block ports
`timescale 1ns/1ps
module cbdc_chk
   import cbdc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] tx_protocol_mode,
   input wire logic [7:0] tx_octet,
   input wire logic tx_octet_valid,
   input wire logic tx_escape_q,
   input wire logic tx_allocated_q,
   input wire logic tx_packet_end_held,
   input wire logic tx_refill_request,
   input wire logic tx_forward_enable,
   input wire logic rx_packet_complete,
   input wire logic rx_forward,
   input wire logic rx_first_request,
   input wire logic rx_fetch_q,
   input wire logic tx_first_request,
   input wire logic tx_fetch_q,
   input wire cbdc_pkg::cbdc_word_type tx_fetch_address_q,
   input wire logic rx_abort_branch_cmd,
   input wire cbdc_pkg::cbdc_word_type rx_list_head_q,
   input wire logic [31:0] channel_event,
   input wire logic tx_vector_write_q,
   input wire logic [31:0] tx_vector_q,
   input wire logic rx_vector_write_q,
   input wire logic [31:0] rx_vector_q
);
   logic tx_ev, rx_ev;
   assign tx_ev = |(channel_event & TX_VECTOR_BITS);
   assign rx_ev = |(channel_event & RX_VECTOR_BITS);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_ESC_MODE: assert property (tx_protocol_mode != 2'h2
      |=> !tx_escape_q) else $error("escape outside ppp");
   AST_ESC_CTRL: assert property (!tx_octet_valid
      || tx_octet > 8'h1f |=> !tx_escape_q) else $error("bad escape");
   AST_END_FWD: assert property (tx_allocated_q && tx_packet_end_held
      |-> tx_forward_enable) else $error("packet end not forwarded");
   AST_ALLOC: assert property (tx_refill_request || tx_forward_enable
      |-> tx_allocated_q) else $error("activity while released");
   AST_RX_DONE: assert property (rx_packet_complete |-> rx_forward)
      else $error("complete packet not forwarded");
   AST_RX_FETCH: assert property (rx_first_request |=> rx_fetch_q)
      else $error("no rx fetch");
   AST_TX_FETCH: assert property (tx_fetch_q
      |-> $past(tx_first_request) && tx_fetch_address_q[1:0] == 2'h0)
      else $error("bad transmit fetch");
   AST_HEAD: assert property (!rx_abort_branch_cmd
      |=> $stable(rx_list_head_q)) else $error("rx head moved");
   AST_TX_VEC: assert property (tx_vector_write_q |-> $past(tx_ev)
      && (tx_vector_q & ~TX_VECTOR_BITS) == 32'h0)
      else $error("bad tx vector");
   AST_RX_VEC: assert property (rx_vector_write_q |-> $past(rx_ev)
      && (rx_vector_q & ~RX_VECTOR_BITS) == 32'h0)
      else $error("bad rx vector");
   AST_QUIET: assert property (channel_event == 32'h0
      |=> !tx_vector_write_q && !rx_vector_write_q)
      else $error("stray vector");
   cover property (tx_forward_enable && !tx_packet_end_held);
   cover property (rx_fetch_q && tx_fetch_q);
   cover property (tx_vector_write_q && rx_vector_write_q);
endmodule

/* File: sim/cbdc_host.sv */
// axi4-lite host model that reaches the channel registers
`timescale 1ns/1ps
module cbdc_host
(
   input wire logic aclk,
   output logic [11:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [11:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready,
   output logic hung
);
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready, hung} = '0;
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
      int n = 0;
      logic done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done && n < 50)
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done)
         hung <= 1'b1;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int n = 0;
      logic done = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done && n < 50)
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done)
         hung <= 1'b1;
   endtask
endmodule

/* File: sim/cbdc_channel_config_tb.sv */
// self-checking bench for the channel config block
`timescale 1ns/1ps
module cbdc_channel_config_tb;
   import cbdc_pkg::*;
   logic aclk, aresetn, hung;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, channel_event, tx_vector_q;
   logic [31:0] rx_vector_q, rx_fetch_address_q, tx_fetch_address_q;
   logic [31:0] rx_list_head_q, tx_list_head_q;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, tx_protocol_mode;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, tx_octet_valid, tx_escape_q;
   logic [7:0] tx_octet;
   logic tx_init_cmd, tx_off_cmd, tx_word_stored, tx_word_taken;
   logic tx_packet_end_held, tx_allocated_q, tx_refill_request;
   logic tx_forward_enable, rx_packet_complete, rx_forward;
   logic rx_code_invalid, tx_refill_code_invalid, rx_first_request;
   logic tx_first_request, rx_abort_branch_cmd, tx_abort_branch_cmd;
   logic rx_fetch_q, tx_fetch_q, tx_vector_write_q, rx_vector_write_q;
   logic [12:0] tx_allocated_words_q;
   logic [9:0] rx_packet_words;
   logic [2:0] tx_vector_queue_q, rx_vector_queue_q;
   int errors = 0;
   int num_checks = 0;
   localparam int thr [16] = '{1, 4, 8, 12, 16, 24, 32, 40, 48, 64, 96, 128,
      192, 256, 384, 512};
   cbdc_channel_config u_dut (.*);
   cbdc_host u_host (.*);
   always #25 aclk = ~aclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge hung)
   begin
      errors++;
      test_done;
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] e);
      logic [1:0] r;
      u_host.wr(a, d, s, r);
      chk(r, e);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
      input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      u_host.rd(a, d, r);
      chk(d, e);
      chk(r, er);
   endtask
   task automatic pul(input logic [5:0] v);
      @(posedge aclk);
      {tx_init_cmd, tx_off_cmd, rx_first_request, tx_first_request,
         rx_abort_branch_cmd, tx_abort_branch_cmd} <= v;
      @(posedge aclk);
      {tx_init_cmd, tx_off_cmd, rx_first_request, tx_first_request,
         rx_abort_branch_cmd, tx_abort_branch_cmd} <= 6'h0;
      #1;
   endtask
   task automatic words(input int n, input logic take);
      repeat (n)
      begin
         @(posedge aclk);
         {tx_word_stored, tx_word_taken} <= {!take, take};
      end
      @(posedge aclk);
      {tx_word_stored, tx_word_taken} <= 2'b00;
      #1;
   endtask
   task automatic ev(input logic [31:0] e);
      @(posedge aclk);
      channel_event <= e;
      @(posedge aclk);
      channel_event <= 32'h0;
      #1;
   endtask
   task automatic t_regs;
      logic [11:0] a [5] = '{12'h018, 12'h020, 12'h024, 12'h028, 12'h02c};
      logic [31:0] m [5] = '{32'hffffffff, 32'hffffff7f, 32'hfffffffc,
         32'hfffffffc, 32'h50c17fed};
      for (int i = 0; i < 5; i++)
      begin
         rd_chk(a[i], (i == 1) ? 32'h00200000 : 32'h0, 2'h0);
         wr(a[i], 32'hffffffff, 4'hf, 2'h0);
         rd_chk(a[i], m[i], 2'h0);
      end
      wr(12'h018, 32'h12345678, 4'h1, 2'h0);
      wr(12'h01c, 32'h0, 4'hf, 2'h2);
      rd_chk(12'h018, 32'hffffff78, 2'h0);
      rd_chk(12'h030, 32'h0, 2'h2);
      $display("register test done");
   endtask
   task automatic t_esc;
      logic [7:0] o [4] = '{8'h00, 8'h0d, 8'h01, 8'h20};
      wr(12'h018, 32'h00002001, 4'hf, 2'h0);
      for (int m = 0; m < 4; m++)
         for (int i = 0; i < 4; i++)
         begin
            @(posedge aclk);
            tx_protocol_mode <= 2'(m);
            tx_octet <= o[i];
            tx_octet_valid <= 1'b1;
            @(posedge aclk);
            tx_octet_valid <= 1'b0;
            #1;
            chk(tx_escape_q, m == 2 && i < 2);
         end
      @(posedge aclk);
      #1;
      chk(tx_escape_q, 1'b0);
      $display("escape test done");
   endtask
   task automatic t_txbuf;
      // size 20 > forward 4 + refill 8
      wr(12'h020, 32'ha0141231, 4'hf, 2'h0);
      chk({tx_allocated_q, tx_refill_request, tx_forward_enable}, 0);
      pul(6'h20);
      chk({tx_allocated_q, tx_allocated_words_q}, {1'b1, 13'd20});
      chk({tx_refill_request, tx_forward_enable}, 2'b10);
      words(3, 1'b0);
      chk(tx_forward_enable, 1'b0);
      words(1, 1'b0);
      chk(tx_forward_enable, 1'b1);
      words(8, 1'b0);
      chk(tx_refill_request, 1'b1);
      words(1, 1'b0);
      chk(tx_refill_request, 1'b0);
      words(1, 1'b1);
      chk(tx_refill_request, 1'b1);
      pul(6'h10);
      chk({tx_allocated_q, tx_refill_request, tx_forward_enable}, 0);
      @(posedge aclk);
      tx_packet_end_held <= 1'b1;
      #1;
      chk(tx_forward_enable, 1'b0);
      pul(6'h20);
      chk(tx_forward_enable, 1'b1);
      @(posedge aclk);
      tx_packet_end_held <= 1'b0;
      wr(12'h020, 32'ha014fa31, 4'hf, 2'h0);
      chk({tx_refill_code_invalid, tx_refill_request}, 2'b10);
      chk(tx_forward_enable, 1'b0);
      pul(6'h10);
      $display("transmit buffer test done");
   endtask
   task automatic t_codes;
      for (int c = 0; c < 16; c++)
      begin
         wr(12'h020, {16'h0014, 4'h0, 4'(c), 4'h0, 4'(c)}, 4'hf, 2'h0);
         chk({rx_code_invalid, tx_refill_code_invalid}, {2{c > 9}});
         @(posedge aclk);
         rx_packet_words <= 10'(thr[c] - 1);
         #1;
         chk(rx_forward, 1'b0);
         @(posedge aclk);
         rx_packet_words <= 10'(thr[c]);
         #1;
         chk(rx_forward, c < 10);
         @(posedge aclk);
         rx_packet_complete <= 1'b1;
         #1;
         chk(rx_forward, 1'b1);
         @(posedge aclk);
         rx_packet_complete <= 1'b0;
      end
      $display("threshold code test done");
   endtask
   task automatic t_desc;
      wr(12'h024, 32'h1234567b, 4'hf, 2'h0);
      wr(12'h028, 32'h89abcdef, 4'hf, 2'h0);
      rd_chk(12'h024, 32'h12345678, 2'h0);
      pul(6'h0c);
      chk({rx_fetch_q, tx_fetch_q}, 2'b11);
      chk(rx_fetch_address_q, 32'h12345678);
      chk(tx_fetch_address_q, 32'h89abcdec);
      chk(rx_list_head_q, 32'h0);
      @(posedge aclk);
      #1;
      chk({rx_fetch_q, tx_fetch_q}, 2'b00);
      pul(6'h03);
      chk(rx_list_head_q, 32'h12345678);
      chk(tx_list_head_q, 32'h89abcdec);
      $display("descriptor test done");
   endtask
   task automatic t_vec;
      wr(12'h020, 32'hc0000010, 4'hf, 2'h0);
      wr(12'h02c, 32'h0, 4'hf, 2'h0);
      ev(32'hffffffff);
      chk({tx_vector_write_q, rx_vector_write_q}, 2'b11);
      chk(tx_vector_q, 32'h50c10000);
      chk(rx_vector_q, 32'h00007fed);
      chk({tx_vector_queue_q, rx_vector_queue_q}, 6'b110001);
      wr(12'h02c, 32'h40000001, 4'hf, 2'h0);
      ev(32'hffffffff);
      chk(tx_vector_q, 32'h10c10000);
      chk(rx_vector_q, 32'h00007fec);
      ev(32'h40000001);
      chk({tx_vector_write_q, rx_vector_write_q}, 2'b00);
      $display("vector mask test done");
   endtask
   initial
   begin
      {aclk, aresetn, tx_protocol_mode, tx_octet, tx_octet_valid} = '0;
      {tx_init_cmd, tx_off_cmd, tx_word_stored, tx_word_taken} = '0;
      {tx_packet_end_held, rx_packet_words, rx_packet_complete} = '0;
      {rx_first_request, tx_first_request, rx_abort_branch_cmd} = '0;
      {tx_abort_branch_cmd, channel_event} = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_esc;
      t_txbuf;
      t_codes;
      t_desc;
      t_vec;
      test_done;
   end
endmodule
bind cbdc_channel_config cbdc_chk u_chk (.*);
